// ===== bench/internal_data_space_decoder_tb.sv
`default_nettype none
module internal_data_space_decoder_tb
  import dspace_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_wbit = 1'b0;
  access_mode_t req_mode = ACC_DIRECT;
  logic [7:0] req_addr = 8'h00, req_wdata = 8'h00;
  logic [2:0] req_reg_sel = 3'h0;
  logic rsp_valid, rsp_rbit, ext_sfr_rd, ext_sfr_wr, ext_sfr_bit_en;
  logic [7:0] rsp_rdata, ext_sfr_addr, ext_sfr_wdata, ext_sfr_rdata;
  logic [7:0] stack_top, status_word, accumulator, aux_operand;
  logic [2:0] ext_sfr_bit_sel;
  logic [15:0] data_pointer;
  int fails = 0, num_checks = 0;
  logic [7:0] rd, e_addr, e_wdata;
  logic rb, e_rd, e_wr, e_ben;
  logic [2:0] e_sel;
  always #4 mclk = ~mclk;
  internal_data_space_decoder dut (.mclk, .rst_n, .req_valid, .req_mode, .req_addr, .req_reg_sel, .req_write,
    .req_wdata, .req_wbit, .rsp_valid, .rsp_rdata, .rsp_rbit, .ext_sfr_rd, .ext_sfr_wr, .ext_sfr_addr,
    .ext_sfr_wdata, .ext_sfr_bit_en, .ext_sfr_bit_sel, .ext_sfr_rdata, .stack_top, .status_word,
    .accumulator, .aux_operand, .data_pointer);
  sfr_periph_model periph (.mclk, .ext_sfr_rd, .ext_sfr_wr, .ext_sfr_addr, .ext_sfr_wdata, .ext_sfr_bit_en,
    .ext_sfr_bit_sel, .ext_sfr_rdata);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one request; peripheral strobes captured a cycle later, answer two cycles later
  task automatic req(input access_mode_t m, input logic [7:0] a, input logic [2:0] s, input logic w,
                     input logic [7:0] d, input logic b);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_mode <= m;
    req_addr <= a;
    req_reg_sel <= s;
    req_write <= w;
    req_wdata <= d;
    req_wbit <= b;
    @(posedge mclk);
    req_valid <= 1'b0;
    // strobes stand only in the cycle after the taking edge, so grab them now
    #1;
    check("early rsp_valid", 16'(rsp_valid), 16'h0);
    {e_rd, e_wr, e_ben, e_sel, e_addr, e_wdata} = {ext_sfr_rd, ext_sfr_wr, ext_sfr_bit_en, ext_sfr_bit_sel,
                                                   ext_sfr_addr, ext_sfr_wdata};
    @(posedge mclk);
    #1;
    check("rsp_valid", 16'(rsp_valid), 16'h1);
    rd = rsp_rdata;
    rb = rsp_rbit;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d); req(ACC_DIRECT, a, 3'h0, 1'b1, d, 1'b0); endtask
  task automatic rdd(input logic [7:0] a); req(ACC_DIRECT, a, 3'h0, 1'b0, 8'h00, 1'b0); endtask
  task automatic s_reset();
    check("stack_top", 16'(stack_top), 16'h07);
    check("regs", {accumulator, aux_operand}, 16'h0000);
    check("dptr", data_pointer, 16'h0000);
    rdd(8'h81);
    check("sp read", 16'(rd), 16'h07);
  endtask
  task automatic s_banks();
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, 8'(b << 3));
      check("bank bits", 16'(status_word[4:3]), 16'(b));
      req(ACC_BANK_REG, 8'h00, 3'(7 - b), 1'b1, 8'(8'h40 + b), 1'b0);
    end
    for (int b = 0; b < 4; b++) begin
      rdd(8'(b * 8 + 7 - b));
      check("bank byte", 16'(rd), 16'(8'h40 + b));
    end
  endtask
  task automatic s_indirect();
    wr(8'hd0, 8'h10);
    req(ACC_BANK_REG, 8'h00, 3'h0, 1'b1, 8'h30, 1'b0);
    req(ACC_BANK_REG, 8'h00, 3'h1, 1'b1, 8'h99, 1'b0);
    req(ACC_INDIRECT, 8'h00, 3'h0, 1'b1, 8'h3c, 1'b0);
    // upper ram value differs from the peripheral's byte at the same address
    req(ACC_INDIRECT, 8'h00, 3'h1, 1'b1, 8'h5b, 1'b0);
    check("indirect quiet", {e_rd, e_wr}, 16'h0);
    rdd(8'h30);
    check("low via direct", 16'(rd), 16'h3c);
    req(ACC_INDIRECT, 8'h00, 3'h1, 1'b0, 8'h00, 1'b0);
    check("upper ram", {e_rd, rd}, 16'h005b);
    rdd(8'h99); // occupied address only, reserved ones are left alone
    check("direct upper", {e_rd, e_addr}, {1'b1, 8'h99});
    check("direct upper data", 16'(rd), 16'(8'h99 ^ 8'h3c));
  endtask
  task automatic s_bits();
    wr(8'h22, 8'h00);
    req(ACC_BIT, 8'h13, 3'h0, 1'b1, 8'h00, 1'b1);
    rdd(8'h22);
    check("bit 13", 16'(rd), 16'h08);
    wr(8'h2f, 8'h00);
    req(ACC_BIT, 8'h7f, 3'h0, 1'b1, 8'h00, 1'b1);
    rdd(8'h2f);
    check("bit 7f", 16'(rd), 16'h80);
    wr(8'h07, 8'h00);
    wr(8'h20, 8'h80);
    req(ACC_BIT, 8'h07, 3'h0, 1'b0, 8'h00, 1'b0);
    check("bit 07", 16'(rb), 16'h1);
    rdd(8'h07);
    check("byte 07", 16'(rd), 16'h00);
  endtask
  task automatic s_sfr_bits();
    wr(8'he0, 8'h00);
    req(ACC_BIT, 8'he3, 3'h0, 1'b1, 8'h00, 1'b1);
    check("acc bit", 16'(accumulator), 16'h08);
    req(ACC_BIT, 8'ha9, 3'h0, 1'b1, 8'h00, 1'b1);
    check("ext bit", {e_wr, e_ben, e_sel, e_addr}, {1'b1, 1'b1, 3'h1, 8'ha8});
    check("ext bit data", 16'(e_wdata), 16'h02);
    rdd(8'ha8);
    check("ext bit read", 16'(rd), 16'h96);
    wr(8'h99, 8'h5a);
    check("ext byte", {e_wr, e_ben, e_wdata}, {1'b1, 1'b0, 8'h5a});
  endtask
  task automatic s_core_regs();
    logic [7:0] ad [4] = '{8'he0, 8'hf0, 8'h82, 8'h83};
    for (int i = 0; i < 4; i++) begin
      wr(ad[i], 8'(8'h12 + 8'h22 * i));
    end
    check("acc aux", {accumulator, aux_operand}, 16'h1234);
    check("dptr", data_pointer, 16'h7856);
    for (int i = 0; i < 4; i++) begin
      rdd(ad[i]);
      check("core read", {e_rd, rd}, 16'(8'h12 + 8'h22 * i));
    end
  endtask
  task automatic s_stack();
    req(ACC_PUSH, 8'h00, 3'h0, 1'b0, 8'h11, 1'b0);
    check("sp push", 16'(stack_top), 16'h08);
    wr(8'hd0, 8'h08);
    req(ACC_BANK_REG, 8'h00, 3'h0, 1'b0, 8'h00, 1'b0);
    check("pushed byte", 16'(rd), 16'h11);
    wr(8'h81, 8'hff);
    req(ACC_PUSH, 8'h00, 3'h0, 1'b0, 8'h22, 1'b0);
    check("sp wrap", 16'(stack_top), 16'h00);
    rdd(8'h00);
    check("wrapped byte", 16'(rd), 16'h22);
    req(ACC_POP, 8'h00, 3'h0, 1'b0, 8'h00, 1'b0);
    check("pop", {stack_top, rd}, 16'hff22);
  endtask
  // reset again mid-run: pointer, bank and strobes must start over
  task automatic s_rereset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    check("sp rereset", 16'(stack_top), 16'h07);
    check("status rereset", 16'(status_word), 16'h00);
    check("strobes rereset", {rsp_valid, ext_sfr_rd, ext_sfr_wr}, 16'h0);
    req(ACC_PUSH, 8'h00, 3'h0, 1'b0, 8'h33, 1'b0);
    check("sp first push", 16'(stack_top), 16'h08);
    // an unknown operand type is answered but changes nothing
    req(access_mode_t'(3'h6), 8'h08, 3'h0, 1'b1, 8'hee, 1'b0);
    check("no-op mode", 16'(stack_top), 16'h08);
    req(ACC_BANK_REG, 8'h00, 3'h0, 1'b0, 8'h00, 1'b0);
    check("bank after reset", 16'(rd), 16'h22);
    rdd(8'h08);
    check("first push byte", 16'(rd), 16'h33);
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    s_reset();
    s_banks();
    s_indirect();
    s_bits();
    s_sfr_bits();
    s_core_regs();
    s_stack();
    s_rereset();
    conclude();
  end
  // watchdog, roughly fourteen times the expected run
  initial begin
    #20us;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire

// ===== bench/sfr_periph_model.sv
`default_nettype none
module sfr_periph_model (
  // clock
  input wire logic mclk,
  // peripheral special register port
  input wire logic ext_sfr_rd,
  input wire logic ext_sfr_wr,
  input wire logic [7:0] ext_sfr_addr,
  input wire logic [7:0] ext_sfr_wdata,
  input wire logic ext_sfr_bit_en,
  input wire logic [2:0] ext_sfr_bit_sel,
  output logic [7:0] ext_sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [256];
  // known seed pattern so reads can be predicted
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'(i) ^ 8'h3c;
    end
  end
  // inverse while not selected, so a stale value can never pass for an answer
  assign ext_sfr_rdata = ext_sfr_rd ? regs[ext_sfr_addr] : ~regs[ext_sfr_addr];
  // a bit write touches only the selected bit
  always @(posedge mclk) begin
    if (ext_sfr_wr && ext_sfr_bit_en) begin
      regs[ext_sfr_addr][ext_sfr_bit_sel] <= ext_sfr_wdata[ext_sfr_bit_sel];
    end else if (ext_sfr_wr) begin
      regs[ext_sfr_addr] <= ext_sfr_wdata;
    end
  end
endmodule
`default_nettype wire

// ===== hw/data_ram_store.sv
`default_nettype none
module data_ram_store
  import dspace_pkg::*;
#(
  parameter int DEPTH = DATA_BYTES,
  parameter int WIDTH = DATA_W
) (
  // clock
  input wire logic mclk,
  // access ports
  ram_port_if.mem port
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // two read ports so a pointer and its target resolve in one cycle
  assign port.ptr_data = mem_reg[port.ptr_addr];
  assign port.rd_data = mem_reg[port.rd_addr];

  // contents are data, left uninitialised by reset like real ram
  always_ff @(posedge mclk) begin
    if (port.wr_en) begin
      mem_reg[port.wr_addr] <= port.wr_data;
    end
  end
endmodule
`default_nettype wire

// ===== hw/dspace_pkg.sv
`default_nettype none
package dspace_pkg;
  // byte and address widths of the internal data space
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_BYTES = 256;
  localparam int BANK_REGS = 8;
  // special register addresses held inside the decoder
  localparam logic [7:0] SFR_STACK_PTR = 8'h81;
  localparam logic [7:0] SFR_DPTR_LOW = 8'h82;
  localparam logic [7:0] SFR_DPTR_HIGH = 8'h83;
  localparam logic [7:0] SFR_STATUS = 8'hd0;
  localparam logic [7:0] SFR_ACCUM = 8'he0;
  localparam logic [7:0] SFR_AUX = 8'hf0;
  // values after reset
  localparam logic [7:0] STACK_PTR_RESET = 8'h07;
  localparam logic [7:0] DPTR_LOW_RESET = 8'h00;
  localparam logic [7:0] DPTR_HIGH_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  // field positions
  localparam int STATUS_BANK_LOW_POS = 3;
  localparam int STATUS_BANK_HIGH_POS = 4;
  localparam int STATUS_PARITY_POS = 0;
  localparam int SPACE_UPPER_POS = 7;
  // bit-addressable byte region starts here (upper nibble used)
  localparam logic [3:0] BIT_REGION_NIBBLE = 4'h2;
  // cycles from request to response
  localparam int RSP_LATENCY = 2;
  // operand access kinds issued by the execution core
  typedef enum logic [2:0] {
    ACC_DIRECT = 3'b000,
    ACC_INDIRECT = 3'b001,
    ACC_BANK_REG = 3'b010,
    ACC_BIT = 3'b011,
    ACC_PUSH = 3'b100,
    ACC_POP = 3'b101
  } access_mode_t;
endpackage
`default_nettype wire

// ===== hw/internal_data_space_decoder.sv
`default_nettype none
// Summary of operation
// - bytes 0x00-0x1F form four banks of eight working registers
// - one bank active, picked by status word bits 3 and 4
// - indirect pointers come from register zero or one of active bank
// - bytes 0x20-0x2F also reachable as 128 bits, bit addresses 0x00-0x7F
// - bit address counts up from byte 0x20 bit zero
// - bit or byte access chosen only by operand type
// - push stores at pointer plus one, then pointer increments
// - stack pointer sits at 0x81 and resets to 0x07
// - stack may sit anywhere in 256 bytes and be 256 deep
// - direct accesses at 0x80-0xFF go to special register space
// - indirect accesses above 0x7F go to upper ram, never special registers
// - lower 128 bytes reachable both directly and indirectly
// - only special registers at x0 or x8 are bit accessible
// - core registers decoded at 0xE0, 0xF0, 0xD0, 0x81, 0x82, 0x83
module internal_data_space_decoder
  import dspace_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // operand request from the execution core
  input wire logic req_valid,
  input wire access_mode_t req_mode,
  input wire logic [7:0] req_addr,
  input wire logic [2:0] req_reg_sel,
  input wire logic req_write,
  input wire logic [7:0] req_wdata,
  input wire logic req_wbit,
  // response, two cycles after the request
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_rbit,
  // peripheral special register port
  output logic ext_sfr_rd,
  output logic ext_sfr_wr,
  output logic [7:0] ext_sfr_addr,
  output logic [7:0] ext_sfr_wdata,
  output logic ext_sfr_bit_en,
  output logic [2:0] ext_sfr_bit_sel,
  input wire logic [7:0] ext_sfr_rdata,
  // core register views
  output logic [7:0] stack_top,
  output logic [7:0] status_word,
  output logic [7:0] accumulator,
  output logic [7:0] aux_operand,
  output logic [15:0] data_pointer
);
  ram_port_if #(.AW(ADDR_W), .DW(DATA_W)) ram ();

  data_ram_store #(.DEPTH(DATA_BYTES), .WIDTH(DATA_W)) u_ram (
    .mclk(mclk),
    .port(ram)
  );

  // core-held special registers
  logic [7:0] stack_top_pointer_reg;
  logic [7:0] data_pointer_low_byte_reg;
  logic [7:0] data_pointer_high_byte_reg;
  logic [7:0] status_word_reg;
  logic [7:0] accumulator_register_reg;
  logic [7:0] auxiliary_operand_reg;
  logic [7:0] stack_top_pointer_next;
  logic [7:0] data_pointer_low_byte_next;
  logic [7:0] data_pointer_high_byte_next;
  logic [7:0] status_word_next;
  logic [7:0] accumulator_register_next;
  logic [7:0] auxiliary_operand_next;

  // pipeline state
  logic s1_valid_reg;
  logic s1_ext_reg;
  logic [7:0] s1_data_reg;
  logic [2:0] s1_idx_reg;
  logic rsp_valid_reg;
  logic [7:0] rsp_rdata_reg;
  logic rsp_rbit_reg;
  logic ext_sfr_rd_reg;
  logic ext_sfr_wr_reg;
  logic [7:0] ext_sfr_addr_reg;
  logic [7:0] ext_sfr_wdata_reg;
  logic ext_sfr_bit_en_reg;
  logic [2:0] ext_sfr_bit_sel_reg;

  // address resolution
  logic [1:0] bank_number;
  logic [7:0] bank_reg_addr;
  logic [7:0] pointer_addr;
  logic [7:0] bit_byte_addr;
  logic [2:0] bit_idx;
  logic is_bit;
  logic is_push;
  logic is_pop;
  logic mode_ok;
  logic [7:0] tgt_addr;
  logic tgt_sfr;
  logic int_hit;
  logic ext_sel;
  logic wr_act;
  logic [7:0] int_sfr_rdata;
  logic [7:0] rd_byte;
  logic [7:0] bit_mask;
  logic [7:0] wr_byte;
  logic sfr_we;
  logic [7:0] s2_byte;

  // bank pick from the status word; bank_select_high is the upper bit
  assign bank_number = {status_word_reg[STATUS_BANK_HIGH_POS],
                        status_word_reg[STATUS_BANK_LOW_POS]};
  assign bank_reg_addr = {3'h0, bank_number, req_reg_sel};
  // only registers zero and one can serve as a pointer
  assign pointer_addr = {3'h0, bank_number, 2'h0, req_reg_sel[0]};

  // bit address split: lower half into 0x20-0x2F, upper half into x0/x8 registers
  assign bit_idx = req_addr[2:0];
  assign bit_byte_addr = req_addr[SPACE_UPPER_POS] ? {req_addr[7:3], 3'h0}
                                                   : {BIT_REGION_NIBBLE, req_addr[6:3]};

  // kind of access comes from the operand type only
  assign is_bit = (req_mode == ACC_BIT);
  assign is_push = (req_mode == ACC_PUSH);
  assign is_pop = (req_mode == ACC_POP);
  assign mode_ok = (req_mode == ACC_DIRECT) || (req_mode == ACC_INDIRECT) ||
                   (req_mode == ACC_BANK_REG) || is_bit || is_push || is_pop;

  // effective address per mode; push pre-increments, pop reads the top
  assign tgt_addr = (req_mode == ACC_DIRECT) ? req_addr :
                    (req_mode == ACC_INDIRECT) ? ram.ptr_data :
                    (req_mode == ACC_BANK_REG) ? bank_reg_addr :
                    is_bit ? bit_byte_addr :
                    is_push ? 8'(stack_top_pointer_reg + 8'h01) :
                    stack_top_pointer_reg;

  // only direct byte or bit operands reach the special register space
  assign tgt_sfr = ((req_mode == ACC_DIRECT) || is_bit) && tgt_addr[SPACE_UPPER_POS];

  // registers kept here; every other special address goes to peripherals
  assign int_hit = (tgt_addr == SFR_STACK_PTR) || (tgt_addr == SFR_DPTR_LOW) ||
                   (tgt_addr == SFR_DPTR_HIGH) || (tgt_addr == SFR_STATUS) ||
                   (tgt_addr == SFR_ACCUM) || (tgt_addr == SFR_AUX);
  assign ext_sel = req_valid && mode_ok && tgt_sfr && !int_hit;
  assign wr_act = mode_ok && (is_push || (req_write && !is_pop));

  // read of the core-held registers
  assign int_sfr_rdata = (tgt_addr == SFR_STACK_PTR) ? stack_top_pointer_reg :
                         (tgt_addr == SFR_DPTR_LOW) ? data_pointer_low_byte_reg :
                         (tgt_addr == SFR_DPTR_HIGH) ? data_pointer_high_byte_reg :
                         (tgt_addr == SFR_STATUS) ? status_word_reg :
                         (tgt_addr == SFR_ACCUM) ? accumulator_register_reg :
                         (tgt_addr == SFR_AUX) ? auxiliary_operand_reg : 8'h00;
  assign rd_byte = tgt_sfr ? int_sfr_rdata : ram.rd_data;

  // a bit write to ram or a core-held register is read-modify-write of the holding byte
  assign bit_mask = 8'h01 << bit_idx;
  assign wr_byte = is_bit ? ((rd_byte & ~bit_mask) | (req_wbit ? bit_mask : 8'h00))
                          : req_wdata;

  // ram port wiring
  assign ram.ptr_addr = pointer_addr;
  assign ram.rd_addr = tgt_addr;
  assign ram.wr_addr = tgt_addr;
  assign ram.wr_data = wr_byte;
  assign ram.wr_en = req_valid && wr_act && !tgt_sfr;

  assign sfr_we = req_valid && wr_act && tgt_sfr && int_hit;

  // next values of the core-held registers; stack math wraps in 8 bits
  assign stack_top_pointer_next =
    (req_valid && is_push) ? 8'(stack_top_pointer_reg + 8'h01) :
    (req_valid && is_pop) ? 8'(stack_top_pointer_reg - 8'h01) :
    (sfr_we && tgt_addr == SFR_STACK_PTR) ? wr_byte : stack_top_pointer_reg;
  assign data_pointer_low_byte_next = (sfr_we && tgt_addr == SFR_DPTR_LOW) ? wr_byte
                                                                          : data_pointer_low_byte_reg;
  assign data_pointer_high_byte_next = (sfr_we && tgt_addr == SFR_DPTR_HIGH) ? wr_byte
                                                                            : data_pointer_high_byte_reg;
  assign accumulator_register_next = (sfr_we && tgt_addr == SFR_ACCUM) ? wr_byte
                                                                      : accumulator_register_reg;
  assign auxiliary_operand_next = (sfr_we && tgt_addr == SFR_AUX) ? wr_byte : auxiliary_operand_reg;
  // parity tracks the accumulator; software writes to it are dropped
  assign status_word_next = {((sfr_we && tgt_addr == SFR_STATUS) ? wr_byte[7:1] : status_word_reg[7:1]),
                             ^accumulator_register_next};

  // core-held register file
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stack_top_pointer_reg <= STACK_PTR_RESET;
      data_pointer_low_byte_reg <= DPTR_LOW_RESET;
      data_pointer_high_byte_reg <= DPTR_HIGH_RESET;
      status_word_reg <= STATUS_RESET;
      accumulator_register_reg <= ACCUM_RESET;
      auxiliary_operand_reg <= AUX_RESET;
    end else begin
      stack_top_pointer_reg <= stack_top_pointer_next;
      data_pointer_low_byte_reg <= data_pointer_low_byte_next;
      data_pointer_high_byte_reg <= data_pointer_high_byte_next;
      status_word_reg <= status_word_next;
      accumulator_register_reg <= accumulator_register_next;
      auxiliary_operand_reg <= auxiliary_operand_next;
    end
  end

  // stage one: capture internal read data, launch peripheral strobes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_valid_reg <= 1'b0;
      s1_ext_reg <= 1'b0;
      s1_data_reg <= 8'h00;
      s1_idx_reg <= 3'h0;
      ext_sfr_rd_reg <= 1'b0;
      ext_sfr_wr_reg <= 1'b0;
      ext_sfr_addr_reg <= 8'h00;
      ext_sfr_wdata_reg <= 8'h00;
      ext_sfr_bit_en_reg <= 1'b0;
      ext_sfr_bit_sel_reg <= 3'h0;
    end else begin
      s1_valid_reg <= req_valid;
      s1_ext_reg <= ext_sel;
      s1_data_reg <= rd_byte;
      s1_idx_reg <= bit_idx;
      ext_sfr_rd_reg <= ext_sel && !wr_act;
      ext_sfr_wr_reg <= ext_sel && wr_act;
      ext_sfr_addr_reg <= ext_sel ? tgt_addr : 8'h00;
      ext_sfr_wdata_reg <= ext_sel ? (is_bit ? (req_wbit ? bit_mask : 8'h00) : req_wdata) : 8'h00;
      ext_sfr_bit_en_reg <= ext_sel && is_bit;
      ext_sfr_bit_sel_reg <= ext_sel ? bit_idx : 3'h0;
    end
  end

  // stage two: the peripheral answers in the cycle its strobe is high
  assign s2_byte = s1_ext_reg ? ext_sfr_rdata : s1_data_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= 8'h00;
      rsp_rbit_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= s1_valid_reg;
      rsp_rdata_reg <= s2_byte;
      rsp_rbit_reg <= s2_byte[s1_idx_reg];
    end
  end

  // outputs straight from flops
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_rdata_reg;
  assign rsp_rbit = rsp_rbit_reg;
  assign ext_sfr_rd = ext_sfr_rd_reg;
  assign ext_sfr_wr = ext_sfr_wr_reg;
  assign ext_sfr_addr = ext_sfr_addr_reg;
  assign ext_sfr_wdata = ext_sfr_wdata_reg;
  assign ext_sfr_bit_en = ext_sfr_bit_en_reg;
  assign ext_sfr_bit_sel = ext_sfr_bit_sel_reg;
  assign stack_top = stack_top_pointer_reg;
  assign status_word = status_word_reg;
  assign accumulator = accumulator_register_reg;
  assign aux_operand = auxiliary_operand_reg;
  assign data_pointer = {data_pointer_high_byte_reg, data_pointer_low_byte_reg};

  // checks
  chk_sp_reset_val: assert property (@(posedge mclk) $rose(rst_n) |-> stack_top == 8'h07)
    else $error("stack pointer not 0x07 after reset");

  chk_push_increment: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_valid && req_mode == ACC_PUSH) |=> stack_top == 8'($past(stack_top) + 8'h01))
    else $error("push did not increment stack pointer");

  chk_push_target: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_valid && req_mode == ACC_PUSH) |-> ram.wr_en && ram.wr_addr == 8'(stack_top + 8'h01))
    else $error("push written away from pointer plus one");

  chk_bank_reg_addr: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_mode == ACC_BANK_REG) |-> ram.rd_addr == {3'h0, status_word[4:3], req_reg_sel})
    else $error("working register address wrong");

  chk_pointer_source: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_mode == ACC_INDIRECT) |-> ram.ptr_addr == {3'h0, status_word[4:3], 2'h0, req_reg_sel[0]})
    else $error("indirect pointer taken from wrong register");

  chk_indirect_ram: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_valid && req_mode == ACC_INDIRECT) |=> !ext_sfr_rd && !ext_sfr_wr)
    else $error("indirect access reached special registers");

  chk_direct_upper: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_valid && req_mode == ACC_DIRECT && req_addr[7] && req_write) |-> !ram.wr_en)
    else $error("direct upper write reached ram");

  chk_bit_low_map: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_mode == ACC_BIT && !req_addr[7]) |-> tgt_addr == 8'(8'h20 + {4'h0, req_addr[6:3]}))
    else $error("bit address mapped to wrong byte");

  chk_bit_sfr_align: assert property (@(posedge mclk) disable iff (!rst_n)
    (req_mode == ACC_BIT && req_addr[7]) |-> tgt_sfr && tgt_addr == {req_addr[7:3], 3'h0})
    else $error("special register bit not on x0 or x8");

  chk_rsp_latency: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid |-> ##2 rsp_valid)
    else $error("response not two cycles after request");
endmodule
`default_nettype wire

// ===== hw/ram_port_if.sv
`default_nettype none
interface ram_port_if #(parameter int AW = 8, parameter int DW = 8);
  logic [AW-1:0] ptr_addr;
  logic [AW-1:0] rd_addr;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] ptr_data;
  logic [DW-1:0] rd_data;
  logic [DW-1:0] wr_data;
  logic wr_en;
  modport ctrl (output ptr_addr, output rd_addr, output wr_addr, output wr_data, output wr_en,
                input ptr_data, input rd_data);
  modport mem (input ptr_addr, input rd_addr, input wr_addr, input wr_data, input wr_en,
               output ptr_data, output rd_data);
endinterface
`default_nettype wire
